// ### hdl/mfiw_irq_core.sv
// Purpose: SPI and UART multi-function interrupt path with wake-up
// Assumes: core strobes are single-cycle pulses on clk_i
// Notes: low-power state is a level from the core
//
// What this block does
// RULE_01: SPI byte done sets the SPI request flag.
// RULE_02: vector only with global, source, group enables set and stack not full; source enables gate only the group flag set, not the take.
// RULE_03: global enable clears when servicing begins.
// RULE_04: servicing clears only the group flag; source flags stay set.
// RULE_05: any of six UART conditions raises the UART request.
// RULE_06: UART conditions reach interrupt logic as pulses.
// RULE_07: UART status flags are never cleared by this block.
// RULE_08: any request flag rising wakes from sleep or idle, ignoring enables.
// RULE_09: a flag already high before sleep gives no wake-up.
// RULE_10: a set flag stays set while masked until serviced or cleared.
// RULE_11: entry pushes only the program counter.
// RULE_12: return from interrupt pops and sets global enable again.
// RULE_13: plain return pops and leaves global enable cleared.
// RULE_14: group flag sets when an enabled member flag is set.
`include "mfiw_defs.svh"
module mfiw_irq_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // event sources
  input wire logic spi_byte_done_i,
  input wire logic [`MFIW_UART_COND_W-1:0] uart_cond_i,
  // software control
  input wire logic serial_periph_irq_enable_i,
  input wire logic uart_irq_enable_i,
  input wire logic group_irq_enable_i,
  input wire logic global_irq_enable_set_i,
  input wire logic global_irq_enable_clr_i,
  input wire logic serial_periph_flag_set_i,
  input wire logic serial_periph_flag_clr_i,
  input wire logic uart_flag_set_i,
  input wire logic uart_flag_clr_i,
  input wire logic group_flag_clr_i,
  // core side
  input wire logic stack_full_i,
  input wire logic low_power_i,
  input wire logic [`MFIW_PC_W-1:0] pc_i,
  input wire logic return_from_interrupt_i,
  input wire logic plain_return_i,
  // outputs
  output logic serial_periph_req_flag_o,
  output logic uart_req_flag_o,
  output logic group_req_flag_o,
  output logic global_irq_enable_o,
  output logic vector_call_o,
  output logic [`MFIW_PC_W-1:0] vector_addr_o,
  output logic stack_push_o,
  output logic [`MFIW_PC_W-1:0] stack_push_data_o,
  output logic stack_pop_o,
  output logic wakeup_o
);
  // ==========================================================
  // request flags
  logic spi_flag, spi_rise, uart_flag, uart_rise, grp_flag, grp_rise;
  logic [`MFIW_UART_COND_W-1:0] cond_prev_reg;
  logic [`MFIW_UART_COND_W-1:0] cond_pulse;
  logic uart_event, spi_set, uart_set, grp_set, grp_clr, take;
  // RULE_06 condition pulses
  // a held level would retrigger the flag after software clears it
  assign cond_pulse = uart_cond_i & ~cond_prev_reg;
  // RULE_05 six condition OR
  assign uart_event = |cond_pulse;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cond_prev_reg <= `MFIW_UART_COND_NONE;
    end else begin
      cond_prev_reg <= uart_cond_i;
    end
  end
  // RULE_01 spi flag set
  assign spi_set = spi_byte_done_i | serial_periph_flag_set_i;
  assign uart_set = uart_event | uart_flag_set_i;
  // RULE_14 group flag set
  // service clear beats the re-set on its own edge; the flag comes back a cycle later
  assign grp_set = ((spi_flag & serial_periph_irq_enable_i) | (uart_flag & uart_irq_enable_i)) & ~take;
  // RULE_04 only group flag cleared
  assign grp_clr = take | group_flag_clr_i;
  // RULE_10 flags hold until cleared
  mfiw_flag_edge u_spi (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .set_i(spi_set),
    .clr_i(serial_periph_flag_clr_i), .flag_o(spi_flag), .rise_o(spi_rise));
  mfiw_flag_edge u_uart (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .set_i(uart_set),
    .clr_i(uart_flag_clr_i), .flag_o(uart_flag), .rise_o(uart_rise));
  mfiw_flag_edge u_grp (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .set_i(grp_set),
    .clr_i(grp_clr), .flag_o(grp_flag), .rise_o(grp_rise));
  // RULE_07 uart status untouched
  // no uart status clear exists here; those flags live in the uart
  // ==========================================================
  // service sequencer
  mfiw_pkg::mfiw_state_type state_reg, state_next;
  logic gie_reg, gie_next, call_reg, push_reg, pop_reg, wake_reg, wake_next;
  logic [`MFIW_PC_W-1:0] push_data_reg;
  logic [`MFIW_PC_W-1:0] vec_addr_reg;
  logic any_ret;
  // RULE_02 take condition
  // a full stack only defers the call; the group flag keeps waiting
  assign take = (state_reg == mfiw_pkg::MFIW_RUN) & gie_reg & group_irq_enable_i & grp_flag & ~stack_full_i;
  assign any_ret = return_from_interrupt_i | plain_return_i;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mfiw_pkg::MFIW_RUN: begin
        if (take) begin
          state_next = mfiw_pkg::MFIW_SERVICE;
        end
      end
      mfiw_pkg::MFIW_SERVICE: begin
        if (any_ret) begin
          state_next = mfiw_pkg::MFIW_RETURN;
        end
      end
      mfiw_pkg::MFIW_RETURN: begin
        state_next = mfiw_pkg::MFIW_RUN;
      end
      // the spare code falls back to run
      default: begin
        state_next = mfiw_pkg::MFIW_RUN;
      end
    endcase
  end
  // global enable next value
  always_comb begin
    gie_next = gie_reg;
    if (global_irq_enable_set_i) begin
      gie_next = `MFIW_RST_HIGH;
    end
    if (global_irq_enable_clr_i) begin
      gie_next = `MFIW_RST_LOW;
    end
    // RULE_12 return re-enables
    // RULE_13 plain return leaves cleared
    if ((state_reg == mfiw_pkg::MFIW_SERVICE) & return_from_interrupt_i) begin
      gie_next = `MFIW_RST_HIGH;
    end
    // RULE_03 clear on service
    if (take) begin
      gie_next = `MFIW_RST_LOW;
    end
  end
  // RULE_08 wake on any rise
  // RULE_09 only edges seen during low power count
  assign wake_next = low_power_i & (spi_rise | uart_rise | grp_rise);
  // sequencer, enable and pulse registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= mfiw_pkg::MFIW_RUN;
      gie_reg <= `MFIW_RST_LOW;
      call_reg <= `MFIW_RST_LOW;
      push_reg <= `MFIW_RST_LOW;
      pop_reg <= `MFIW_RST_LOW;
      wake_reg <= `MFIW_RST_LOW;
      push_data_reg <= `MFIW_PC_ZERO;
      vec_addr_reg <= `MFIW_VEC_ADDR;
    end else begin
      state_reg <= state_next;
      gie_reg <= gie_next;
      call_reg <= take;
      // RULE_11 push pc only
      push_reg <= take;
      pop_reg <= (state_reg == mfiw_pkg::MFIW_SERVICE) & any_ret;
      wake_reg <= wake_next;
      vec_addr_reg <= `MFIW_VEC_ADDR;
      if (take) begin
        push_data_reg <= pc_i;
      end
    end
  end
  // outputs come straight from registers
  assign serial_periph_req_flag_o = spi_flag;
  assign uart_req_flag_o = uart_flag;
  assign group_req_flag_o = grp_flag;
  assign global_irq_enable_o = gie_reg;
  assign vector_call_o = call_reg;
  assign vector_addr_o = vec_addr_reg;
  assign stack_push_o = push_reg;
  assign stack_push_data_o = push_data_reg;
  assign stack_pop_o = pop_reg;
  assign wakeup_o = wake_reg;
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  call_gie_clear_a: assert property (take |=> vector_call_o && !global_irq_enable_o) // RULE_03
    else $error("global enable not cleared on vector call");
  call_needs_en_a: assert property (vector_call_o |-> !$past(stack_full_i) && $past(global_irq_enable_o) // RULE_02
    && $past(group_irq_enable_i) && $past(group_req_flag_o))
    else $error("vector taken while disabled or stack full");
  group_clear_a: assert property (take |=> !group_req_flag_o) // RULE_04
    else $error("group flag not cleared on service");
  source_keep_a: assert property ((take && spi_flag && !serial_periph_flag_clr_i) |=> serial_periph_req_flag_o) // RULE_04
    else $error("spi flag cleared by service");
  spi_set_a: assert property (spi_byte_done_i |=> serial_periph_req_flag_o) // RULE_01
    else $error("spi flag not set by byte done");
  uart_set_a: assert property ($rose(uart_cond_i[0]) |=> uart_req_flag_o) // RULE_05
    else $error("uart flag not set by condition");
  flag_hold_a: assert property ((uart_flag && !uart_flag_clr_i) |=> uart_flag) // RULE_10
    else $error("uart flag dropped while masked");
  push_pc_a: assert property (take |=> stack_push_o && stack_push_data_o == $past(pc_i)) // RULE_11
    else $error("pushed value is not pc");
  irq_ret_gie_a: assert property ((state_reg == mfiw_pkg::MFIW_SERVICE && return_from_interrupt_i // RULE_12
    && !take && !global_irq_enable_clr_i) |=> global_irq_enable_o && stack_pop_o)
    else $error("return from interrupt did not restore global enable");
  ret_gie_a: assert property ((state_reg == mfiw_pkg::MFIW_SERVICE && plain_return_i && !return_from_interrupt_i
    && !global_irq_enable_set_i && !gie_reg) |=> !global_irq_enable_o && stack_pop_o) // RULE_13
    else $error("plain return changed global enable");
  wake_rise_a: assert property ((low_power_i && $rose(spi_flag)) |=> wakeup_o) // RULE_08
    else $error("no wake on flag rise");
  wake_held_a: assert property ((wakeup_o) |-> $past(low_power_i)) // RULE_09
    else $error("wake outside low power");
  pop_in_service_a: assert property (stack_pop_o |-> $past(state_reg) == mfiw_pkg::MFIW_SERVICE) // RULE_12
    else $error("pop outside a service routine");
  uart_pulse_a: assert property ((uart_req_flag_o && uart_flag_clr_i && !uart_flag_set_i // RULE_06
    && $stable(uart_cond_i)) |=> !uart_req_flag_o)
    else $error("held uart condition set the flag again");
  wake_uart_a: assert property ((low_power_i && $rose(uart_req_flag_o)) |=> wakeup_o) // RULE_08
    else $error("no wake on uart flag rise");
  // main scenarios
  take_cov_c: cover property (take ##1 vector_call_o);
  irq_ret_cov_c: cover property (stack_pop_o && global_irq_enable_o);
  plain_ret_cov_c: cover property (stack_pop_o && !global_irq_enable_o);
  wake_cov_c: cover property (wakeup_o);
endmodule // mfiw_irq_core

// ### hdl/mfiw_defs.svh
// Purpose: named constants for the multi-function interrupt and wake-up block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef MFIW_DEFS_SVH
`define MFIW_DEFS_SVH
`define MFIW_RST_LOW 1'h0
`define MFIW_RST_HIGH 1'h1
`define MFIW_UART_COND_W 6
`define MFIW_UART_COND_NONE 6'h00
`define MFIW_PC_W 13
`define MFIW_PC_ZERO 13'h0000
`define MFIW_VEC_ADDR 13'h0014
`endif

// ### hdl/mfiw_pkg.sv
// Purpose: types for the multi-function interrupt and wake-up block
// Assumes: nothing
// Notes: one sequencer state enum
package mfiw_pkg;
  typedef enum logic [1:0] {
    MFIW_RUN,
    MFIW_SERVICE,
    MFIW_RETURN
  } mfiw_state_type;
endpackage

// ### hdl/mfiw_flag_edge.sv
// Purpose: one request flag with set-over-clear and a rise detector
// Assumes: set and clear come from logic on clk_i
// Notes: rise pulse feeds the wake-up path
`include "mfiw_defs.svh"
module mfiw_flag_edge (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // flag control
  input wire logic set_i,
  input wire logic clr_i,
  // flag and its rise
  output logic flag_o,
  output logic rise_o
);
  logic flag_reg;
  logic flag_next;
  logic rise_reg;
  logic rise_next;
  // set wins over a clear in the same cycle
  assign flag_next = set_i | (flag_reg & ~clr_i);
  assign rise_next = flag_next & ~flag_reg;
  // flag and edge state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_reg <= `MFIW_RST_LOW;
      rise_reg <= `MFIW_RST_LOW;
    end else begin
      flag_reg <= flag_next;
      rise_reg <= rise_next;
    end
  end
  assign flag_o = flag_reg;
  assign rise_o = rise_reg;
endmodule // mfiw_flag_edge

// ### tb/mfiw_core_model.sv
// Purpose: behavioural sequencer and stack facing the irq block
// Assumes: push and pop are one-cycle pulses on clk_i
// Notes: used_i stands for stack entries held by software calls
`include "mfiw_defs.svh"
module mfiw_core_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // stack traffic from the irq block
  input wire logic push_i,
  input wire logic [`MFIW_PC_W-1:0] push_data_i,
  input wire logic pop_i,
  input wire logic [`MFIW_PC_W-1:0] vec_i,
  input wire logic [1:0] used_i,
  // sequencer view
  output logic [`MFIW_PC_W-1:0] pc_o,
  output logic full_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // stack
  logic [`MFIW_PC_W-1:0] stack_reg [DEPTH];
  int depth_reg;
  // software frames count too, so a deep call chain blocks vectoring
  assign full_o = (depth_reg + int'(used_i)) >= DEPTH;
  // pc parks until a call jumps it and a pop brings it back
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      depth_reg <= 0;
      pc_o <= 13'h0123;
    end else if (push_i && depth_reg < DEPTH) begin
      stack_reg[depth_reg] <= push_data_i;
      depth_reg <= depth_reg + 1;
      pc_o <= vec_i;
    end else if (pop_i && depth_reg > 0) begin
      depth_reg <= depth_reg - 1;
      pc_o <= stack_reg[depth_reg-1];
    end
  end
endmodule // mfiw_core_model

// ### tb/mfiw_irq_core_test.sv
// Purpose: directed test of the multi-function irq and wake-up path
// Assumes: inputs change on the falling edge, outputs read there
// Notes: waits are fixed cycle counts from the hand-over timing
`include "mfiw_defs.svh"
module mfiw_irq_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // wiring
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic low_pwr = 1'h0;
  logic [9:0] st = 10'h000;
  logic [2:0] en = 3'h0;
  logic [1:0] used = 2'h0;
  logic [5:0] cond = 6'h00;
  logic [2:0] seen;
  logic [12:0] pdat, pc, vaddr, pushd;
  logic gflag, full, serial_periph_req_flag, urf, grf, gie, vec, push, pop, wake;
  int errors = 0;
  int check_count = 0;
  always #25 clk_i = ~clk_i;
  mfiw_irq_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_byte_done_i(st[0]), .uart_cond_i(cond),
    .serial_periph_irq_enable_i(en[0]), .uart_irq_enable_i(en[1]), .group_irq_enable_i(en[2]),
    .global_irq_enable_set_i(st[1]), .global_irq_enable_clr_i(st[2]), .serial_periph_flag_set_i(st[3]),
    .serial_periph_flag_clr_i(st[4]), .uart_flag_set_i(st[5]), .uart_flag_clr_i(st[6]), .group_flag_clr_i(st[7]),
    .stack_full_i(full), .low_power_i(low_pwr), .pc_i(pc), .return_from_interrupt_i(st[8]), .plain_return_i(st[9]),
    .serial_periph_req_flag_o(serial_periph_req_flag), .uart_req_flag_o(urf), .group_req_flag_o(grf), .global_irq_enable_o(gie),
    .vector_call_o(vec), .vector_addr_o(vaddr), .stack_push_o(push), .stack_push_data_o(pushd),
    .stack_pop_o(pop), .wakeup_o(wake));
  mfiw_core_model #(.DEPTH(2)) u_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .push_i(push), .push_data_i(pushd),
    .pop_i(pop), .vec_i(vaddr), .used_i(used), .pc_o(pc), .full_o(full));
  // ==========
  // tasks
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // a gap edge first, so back-to-back strobes never share a time step
  task automatic strobe(input logic [9:0] m);
    @(negedge clk_i);
    st = m;
    @(negedge clk_i);
    st = 10'h000;
  endtask
  // pulses stand one cycle, so they are caught as they pass; the call's own edge counts too
  task automatic run(input int n);
    seen = 3'h0;
    for (int i = 0; i <= n; i++) begin
      if (i > 0) @(negedge clk_i);
      seen = seen | {wake, pop, vec};
      if (push) pdat = pushd;
      if (vec) gflag = grf;
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'h0;
    // each uart condition alone; a held level must not re-arm the flag
    en = 3'h6;
    for (int k = 0; k < 6; k++) begin
      cond = 6'h01 << k;
      run(3);
      chk(urf, 1'h1);
      chk(grf, 1'h1);
      chk(seen[0], 1'h0);
      strobe(10'h040);
      strobe(10'h080);
      run(2);
      chk(urf, 1'h0);
      chk(grf, 1'h0);
      cond = 6'h00;
      run(1);
    end
    // spi take, then return from interrupt
    en = 3'h5;
    strobe(10'h002);
    chk(gie, 1'h1);
    strobe(10'h001);
    run(4);
    chk(serial_periph_req_flag, 1'h1);
    chk(seen[0], 1'h1);
    chk(pdat, 13'h0123);
    chk(gflag, 1'h0);
    chk(gie, 1'h0);
    run(4);
    chk(seen[0], 1'h0);
    chk(serial_periph_req_flag, 1'h1);
    chk(vaddr, `MFIW_VEC_ADDR);
    strobe(10'h010);
    strobe(10'h080);
    strobe(10'h100);
    run(2);
    chk(seen[1], 1'h1);
    chk(gie, 1'h1);
    // full stack holds the take off; plain return keeps gie low
    used = 2'h2;
    strobe(10'h008);
    run(4);
    chk(seen[0], 1'h0);
    used = 2'h0;
    run(3);
    chk(seen[0], 1'h1);
    strobe(10'h010);
    strobe(10'h080);
    strobe(10'h200);
    run(2);
    chk(seen[1], 1'h1);
    chk(gie, 1'h0);
    strobe(10'h100);
    run(2);
    chk(seen[1], 1'h0);
    // wake on a rising flag with every enable off
    en = 3'h0;
    low_pwr = 1'h1;
    strobe(10'h020);
    run(3);
    chk(seen[2], 1'h1);
    strobe(10'h020);
    run(3);
    chk(seen[2], 1'h0);
    report_and_stop();
  end
endmodule // mfiw_irq_core_test
